// ===== logic/vpd_decoder.sv
// downlink pulse position decoder of the vicinity tag receiver
`timescale 1ns/1ps
`default_nettype none
`include "vpd_consts.svh"

module vpd_decoder
#(
   parameter int unsigned PWRUP_CYC = `VPD_PWRUP_CYC,
   parameter int unsigned TURN_CYC  = `VPD_TURN_CYC
)
(
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic             carrier_clk,
   input  wire logic             pause_n,
   input  wire logic             field_on,
   input  wire logic             resp_done,
   output var  logic             rx_ready,
   output var  vpd_pkg::vpd_evt_t rx_evt
);

   localparam int unsigned TW = 20;
   if (PWRUP_CYC < 9 || PWRUP_CYC >= (1 << TW))
      $error("PWRUP_CYC out of range");
   if (TURN_CYC < 9 || TURN_CYC >= (1 << TW))
      $error("TURN_CYC out of range");

   ////////////////////////////////////////////////////////////////////////
   logic field_lvl;
   logic field_rise;
   logic ce;
   logic pf;
   vpd_pin_sync u_car
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     (carrier_clk),
      .lvl     (),
      .rise    (ce),
      .fall    ()
   );
   vpd_pin_sync u_pause
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     (pause_n),
      .lvl     (),
      .rise    (),
      .fall    (pf)
   );
   vpd_pin_sync u_field
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     (field_on),
      .lvl     (field_lvl),
      .rise    (field_rise),
      .fall    ()
   );

   ////////////////////////////////////////////////////////////////////////
   vpd_pkg::vpd_state_t state_q;
   vpd_pkg::vpd_state_t state_d;
   vpd_pkg::vpd_mode_t  mode_q;
   vpd_pkg::vpd_mode_t  mode_d;
   vpd_pkg::vpd_evt_t   evt_d;
   logic [15:0]         cnt_q;
   logic [15:0]         cnt_d;
   logic [7:0]          shf_q;
   logic [7:0]          shf_d;
   logic [1:0]          pairs_q;
   logic [1:0]          pairs_d;
   logic                seen_q;
   logic                seen_d;
   logic [TW-1:0]       tmr_q;
   logic [TW-1:0]       tmr_d;
   logic                ready_d;
   logic [15:0]         pos;

   assign pos = cnt_q + {15'h0000, ce}; // includes a rise seen with a pause
   always_comb
   begin
      logic [7:0] slot;
      logic       wrap;
      slot    = 8'h00;
      wrap    = 1'b0;
      state_d = state_q;
      mode_d  = mode_q;
      cnt_d   = cnt_q;
      shf_d   = shf_q;
      pairs_d = pairs_q;
      seen_d  = seen_q;
      tmr_d   = tmr_q;
      evt_d   = '0;
      evt_d.data = rx_evt.data;
      // pause positions are measured in recovered carrier cycles
      if (ce)
         cnt_d = cnt_q + 16'h0001;
      case (state_q)
         vpd_pkg::VPD_S_OFF:
         begin
            if (field_lvl)
            begin
               state_d = vpd_pkg::VPD_S_PWR;
               tmr_d   = TW'(PWRUP_CYC - 1);
            end
         end
         vpd_pkg::VPD_S_PWR, vpd_pkg::VPD_S_IDLE:
         begin
            // no frame is taken before the power-up or turnaround time
            if (state_q == vpd_pkg::VPD_S_PWR)
            begin
               tmr_d = tmr_q - TW'(1);
               if (tmr_q == '0)
                  state_d = vpd_pkg::VPD_S_IDLE;
            end
            else if (pf)
            begin
               state_d = vpd_pkg::VPD_S_SOF;
               cnt_d   = 16'h0000;
            end
         end
         vpd_pkg::VPD_S_SOF:
         begin
            // second pause spacing picks the mode afresh per frame
            if (pf)
            begin
               evt_d.frame_start = 1'b1;
               state_d = vpd_pkg::VPD_S_SOFT;
               if (cnt_q >= `VPD_SOF4_GAP - `VPD_GAP_TOL &&
                   cnt_q <= `VPD_SOF4_GAP + `VPD_GAP_TOL)
                  mode_d = vpd_pkg::VPD_MODE_4;
               else if (cnt_q >= `VPD_SOF256_GAP - `VPD_GAP_TOL &&
                        cnt_q <= `VPD_SOF256_GAP + `VPD_GAP_TOL)
                  mode_d = vpd_pkg::VPD_MODE_256;
               else
               begin
                  evt_d.frame_start = 1'b0;
                  evt_d.frame_error = 1'b1;
                  state_d = vpd_pkg::VPD_S_IDLE;
               end
            end
            else if (cnt_q > `VPD_SOF256_GAP + `VPD_GAP_TOL)
            begin
               evt_d.frame_error = 1'b1;
               state_d = vpd_pkg::VPD_S_IDLE;
            end
         end
         vpd_pkg::VPD_S_SOFT:
         begin
            if (pf)
            begin
               evt_d.frame_error = 1'b1;
               state_d = vpd_pkg::VPD_S_IDLE;
            end
            else if (cnt_q == `VPD_SOF_LEN)
            begin
               state_d = vpd_pkg::VPD_S_DATA;
               cnt_d   = 16'h0000;
               seen_d  = 1'b0;
               pairs_d = 2'b00;
            end
         end
         vpd_pkg::VPD_S_DATA:
         begin
            // depth of the pause does not matter, only its leading edge
            slot = (mode_q == vpd_pkg::VPD_MODE_4) ? {6'h00, pos[9:8]}
                                                   : pos[15:8];
            wrap = ce && ((mode_q == vpd_pkg::VPD_MODE_4) ?
                          cnt_q[9:0] == `VPD_SYM4_LAST :
                          cnt_q == `VPD_SYM256_LAST);
            if (pf && pos[7:0] < `VPD_HALF_FC && (wrap ? seen_q : !seen_q))
            begin
               // symbol-start pause after a full symbol opens end pattern
               state_d = vpd_pkg::VPD_S_EOF;
               cnt_d   = 16'h0000;
            end
            else if (pf && !seen_q && !wrap)
            begin
               // data pause sits in the second half of its slot
               seen_d = 1'b1;
               if (mode_q == vpd_pkg::VPD_MODE_256)
               begin
                  evt_d.data       = slot;
                  evt_d.byte_valid = 1'b1;
               end
               else
               begin
                  shf_d   = {slot[1:0], shf_q[7:2]};
                  pairs_d = pairs_q + 2'b01;
                  if (pairs_q == 2'b11)
                  begin
                     evt_d.data       = {slot[1:0], shf_q[7:2]};
                     evt_d.byte_valid = 1'b1;
                  end
               end
            end
            else if (pf || (wrap && !seen_q))
            begin
               evt_d.frame_error = 1'b1;
               state_d = vpd_pkg::VPD_S_IDLE;
            end
            if (wrap && state_d == vpd_pkg::VPD_S_DATA)
            begin
               cnt_d  = 16'h0000;
               seen_d = 1'b0;
            end
         end
         vpd_pkg::VPD_S_EOF:
         begin
            if (pf && pairs_q == 2'b00 &&
                cnt_q >= `VPD_EOF_GAP - `VPD_GAP_TOL &&
                cnt_q <= `VPD_EOF_GAP + `VPD_GAP_TOL)
            begin
               evt_d.frame_end = 1'b1;
               state_d = vpd_pkg::VPD_S_WAIT;
            end
            else if (pf || cnt_q > `VPD_EOF_GAP + `VPD_GAP_TOL)
            begin
               evt_d.frame_error = 1'b1;
               state_d = vpd_pkg::VPD_S_IDLE;
            end
         end
         vpd_pkg::VPD_S_WAIT:
         begin
            // the tag answers before the reader may talk again
            if (resp_done)
            begin
               state_d = vpd_pkg::VPD_S_PWR;
               tmr_d   = TW'(TURN_CYC - 1);
            end
         end
         default:
            state_d = vpd_pkg::VPD_S_OFF;
      endcase
      if (!field_lvl)
         state_d = vpd_pkg::VPD_S_OFF;
      evt_d.mode = mode_d;
      ready_d    = (state_d == vpd_pkg::VPD_S_IDLE);
   end
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q  <= vpd_pkg::VPD_S_OFF;
         mode_q   <= vpd_pkg::VPD_MODE_4;
         cnt_q    <= 16'h0000;
         shf_q    <= 8'h00;
         pairs_q  <= 2'b00;
         seen_q   <= 1'b0;
         tmr_q    <= '0;
         rx_ready <= 1'b0;
         rx_evt   <= '0;
      end
      else
      begin
         state_q  <= state_d;
         mode_q   <= mode_d;
         cnt_q    <= cnt_d;
         shf_q    <= shf_d;
         pairs_q  <= pairs_d;
         seen_q   <= seen_d;
         tmr_q    <= tmr_d;
         rx_ready <= ready_d;
         rx_evt   <= evt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_off_not_ready: assert property (
      !field_lvl |=> !rx_ready)
      else $error("ready while field is off");
   a_pwrup_hold: assert property (
      field_rise |-> !rx_ready [*8])
      else $error("ready too early after power-up");
   a_turn_hold: assert property (
      (state_q == vpd_pkg::VPD_S_WAIT && resp_done) |=> !rx_ready [*8])
      else $error("ready too early after response");
   a_end_no_ready: assert property (
      rx_evt.frame_end |-> !rx_ready ##1 !rx_ready)
      else $error("ready before response after frame end");
   a_valid_pulse: assert property (
      rx_evt.byte_valid |=> !rx_evt.byte_valid)
      else $error("byte strobe longer than one cycle");
   a_start_sof: assert property (
      rx_evt.frame_start |-> state_q == vpd_pkg::VPD_S_SOFT &&
                             $past(state_q) == vpd_pkg::VPD_S_SOF)
      else $error("frame start without start pattern");
   a_mode_hold: assert property (
      (state_q == vpd_pkg::VPD_S_DATA &&
       $past(state_q) == vpd_pkg::VPD_S_DATA) |-> $stable(mode_q))
      else $error("mode changed inside a frame");
   a_byte_data: assert property (
      rx_evt.byte_valid |-> $past(state_q) == vpd_pkg::VPD_S_DATA)
      else $error("byte outside data phase");
   a_pair_byte: assert property (
      (rx_evt.byte_valid && rx_evt.mode == vpd_pkg::VPD_MODE_4)
         |-> pairs_q == 2'b00 && rx_evt.data[7:2] == shf_q[7:2])
      else $error("1-of-4 byte not built from four pairs");
   a_slot_zero: assert property (
      (state_q == vpd_pkg::VPD_S_DATA && mode_q == vpd_pkg::VPD_MODE_256
       && pf && !seen_q && pos[15:7] == 9'h001 && field_lvl)
         |=> rx_evt.byte_valid && rx_evt.data == 8'h00)
      else $error("first slot did not decode to zero");
   a_err_idle: assert property (
      rx_evt.frame_error |-> state_q inside {vpd_pkg::VPD_S_IDLE,
                                             vpd_pkg::VPD_S_OFF})
      else $error("frame not abandoned on error");

   c_frame4: cover property (
      rx_evt.frame_end && rx_evt.mode == vpd_pkg::VPD_MODE_4);
   c_byte256: cover property (
      rx_evt.byte_valid && rx_evt.mode == vpd_pkg::VPD_MODE_256);
   c_error: cover property (rx_evt.frame_error);
   c_turn: cover property ($rose(rx_ready) && $past(state_q) ==
                           vpd_pkg::VPD_S_PWR && field_lvl);

endmodule
`default_nettype wire

// ===== logic/vpd_consts.svh
// timing and coding constants of the downlink pulse position decoder
`ifndef VPD_CONSTS_SVH
`define VPD_CONSTS_SVH

// carrier cycles per slot and half slot
`define VPD_SLOT_FC      16'h0100
`define VPD_HALF_FC      8'h80
// last carrier count of a 1-of-4 symbol (4 slots)
`define VPD_SYM4_LAST    10'h3FF
// last carrier count of a 1-of-256 symbol (256 slots)
`define VPD_SYM256_LAST  16'hFFFF
// pause-to-pause spacing of the two start patterns and the end pattern
`define VPD_SOF4_GAP     16'h0280
`define VPD_SOF256_GAP   16'h0300
`define VPD_EOF_GAP      16'h0280
// accepted deviation on a delimiter spacing
`define VPD_GAP_TOL      16'h0020
// length of the start pattern, counted from its first pause
`define VPD_SOF_LEN      16'h0400

// local clock period and readiness times
`define VPD_CLK_NS       8
`define VPD_T_PWRUP_NS   100000
`define VPD_T_TURN_NS    311500
`define VPD_PWRUP_CYC    ((`VPD_T_PWRUP_NS + `VPD_CLK_NS - 1) / `VPD_CLK_NS)
`define VPD_TURN_CYC     ((`VPD_T_TURN_NS + `VPD_CLK_NS - 1) / `VPD_CLK_NS)

`endif

// ===== logic/vpd_pkg.sv
// types shared by the downlink decoder
package vpd_pkg;

   typedef enum logic
   {
      VPD_MODE_4,
      VPD_MODE_256
   } vpd_mode_t;

   typedef enum logic [2:0]
   {
      VPD_S_OFF,
      VPD_S_PWR,
      VPD_S_IDLE,
      VPD_S_SOF,
      VPD_S_SOFT,
      VPD_S_DATA,
      VPD_S_EOF,
      VPD_S_WAIT
   } vpd_state_t;

   typedef struct packed
   {
      logic [7:0] data;
      logic       byte_valid;
      logic       frame_start;
      logic       frame_end;
      logic       frame_error;
      vpd_mode_t  mode;
   } vpd_evt_t;

endpackage

// ===== logic/vpd_pin_sync.sv
// three-stage pin synchroniser with filtered level and edge pulses
`timescale 1ns/1ps
`default_nettype none

module vpd_pin_sync
(
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic din,
   output var  logic lvl,
   output var  logic rise,
   output var  logic fall
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_d;

   // level follows only once stages two and three agree
   always_comb
   begin
      lvl_d = (s2_q == s3_q) ? s3_q : lvl;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl  <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl  <= lvl_d;
         rise <= lvl_d & ~lvl;
         fall <= ~lvl_d & lvl;
      end
   end

endmodule

`default_nettype wire

// ===== tb/vpd_rdr_model.sv
// reader side model: free running carrier, field and pause patterns
`timescale 1ns/1ps
`default_nettype none

module vpd_rdr_model
(
   output var logic carrier_clk,
   output var logic pause_n,
   output var logic field_on
);

   // carrier runs free, field and pauses are set by the tasks below
   initial
   begin
      carrier_clk = 1'b0;
      pause_n     = 1'b1;
      field_on    = 1'b0;
      forever #62.5 carrier_clk = ~carrier_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic w(input int n);
      repeat (n) @(posedge carrier_clk);
   endtask

   task automatic field(input logic on);
      field_on <= on;
   endtask

   // one pause of 16 carrier cycles, depth is hidden by the front end
   task automatic pz();
      pause_n <= 1'b0;
      w(16);
      pause_n <= 1'b1;
   endtask

   // start pattern, the spacing of the second pause picks the mode
   task automatic sof(input int gap);
      w(1);
      pz();
      w(gap - 16);
      pz();
      w(1024 - gap - 16);
   endtask

   // one symbol of len counts, pause in the second half of slot s
   task automatic sym(input int s, input int len);
      w(s * 256 + 128);
      pz();
      w(len - s * 256 - 144);
   endtask

   // end pattern, first pause at a symbol start
   task automatic eof();
      pz();
      w(624);
      pz();
   endtask

endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the downlink decoder
`timescale 1ns/1ps
`default_nettype none

module tb_top;

   localparam int unsigned P_CYC = 16;

   logic              ref_clk;
   logic              nrst;
   logic              resp_done;
   logic              carrier_clk;
   logic              pause_n;
   logic              field_on;
   logic              rx_ready;
   vpd_pkg::vpd_evt_t rx_evt;
   int                n_mismatch = 0;
   int                checks     = 0;
   int                n_byte     = 0;
   int                n_start    = 0;
   int                n_end      = 0;
   int                n_err      = 0;
   logic [7:0]        last_data  = 8'h00;
   logic              bv_prev    = 1'b0;
   logic [7:0]        b;
   int                cnt;

   vpd_rdr_model rdr
   (
      .carrier_clk (carrier_clk),
      .pause_n     (pause_n),
      .field_on    (field_on)
   );

   vpd_decoder #(.PWRUP_CYC(P_CYC), .TURN_CYC(P_CYC)) dut
   (
      .ref_clk     (ref_clk),
      .nrst        (nrst),
      .carrier_clk (carrier_clk),
      .pause_n     (pause_n),
      .field_on    (field_on),
      .resp_done   (resp_done),
      .rx_ready    (rx_ready),
      .rx_evt      (rx_evt)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic wait_ready(input int lim, output int c);
      c = 0;
      while (rx_ready !== 1'b1)
      begin
         @(posedge ref_clk);
         #1; // look once the edge's register updates have landed
         c++;
         if (c > lim)
         begin
            n_mismatch++;
            wrap_up();
         end
      end
   endtask

   task automatic settle();
      repeat (10) @(posedge ref_clk);
   endtask

   function automatic int pair_of(input logic [7:0] v, input int k);
      return (v >> (2 * k)) & 3;
   endfunction

   // event monitor, the byte strobe must last a single cycle
   always @(posedge ref_clk)
   begin
      bv_prev <= rx_evt.byte_valid;
      if (rx_evt.byte_valid === 1'b1 && bv_prev === 1'b1)
         chk("byte_valid width", 8'h01, 8'h00);
      if (rx_evt.byte_valid === 1'b1)
      begin
         n_byte    <= n_byte + 1;
         last_data <= rx_evt.data;
      end
      if (rx_evt.frame_start === 1'b1)
         n_start <= n_start + 1;
      if (rx_evt.frame_end === 1'b1)
         n_end <= n_end + 1;
      if (rx_evt.frame_error === 1'b1)
         n_err <= n_err + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      nrst      = 1'b0;
      resp_done = 1'b0;
      void'($urandom(18));
      repeat (8) @(posedge ref_clk);
      #2 nrst = 1'b1;
      repeat (30) @(posedge ref_clk);
      chk("ready without field", 8'(rx_ready), 8'h00);
      rdr.field(1'b1);
      wait_ready(200, cnt);
      chk("power-up wait", 8'(cnt > P_CYC && cnt < P_CYC + 8), 8'h01);
      // 1-of-4 frame, slots 0 and 3 always present
      b = {2'h3, 4'($urandom), 2'h0};
      rdr.sof(640);
      for (int k = 0; k < 4; k++)
         rdr.sym(pair_of(b, k), 1024);
      rdr.eof();
      settle();
      chk("byte count", 8'(n_byte), 8'h01);
      chk("byte 1of4", last_data, b);
      chk("mode 1of4", 8'(rx_evt.mode), 8'h00);
      chk("starts", 8'(n_start), 8'h01);
      chk("ends", 8'(n_end), 8'h01);
      repeat (40) @(posedge ref_clk);
      chk("ready before answer", 8'(rx_ready), 8'h00);
      @(posedge ref_clk);
      resp_done <= 1'b1;
      @(posedge ref_clk);
      resp_done <= 1'b0;
      wait_ready(200, cnt);
      chk("turnaround", 8'(cnt >= P_CYC - 1 && cnt <= P_CYC + 3), 8'h01);
      // 1-of-256 frame, pause in the earliest slot
      rdr.sof(768);
      rdr.sym(0, 144);
      settle();
      chk("byte count 256", 8'(n_byte), 8'h02);
      chk("byte 1of256", last_data, 8'h00);
      chk("mode 1of256", 8'(rx_evt.mode), 8'h01);
      chk("starts 256", 8'(n_start), 8'h02);
      rdr.field(1'b0);
      settle();
      chk("ready field off", 8'(rx_ready), 8'h00);
      rdr.field(1'b1);
      wait_ready(200, cnt);
      // spacing that selects no mode
      rdr.sof(500);
      settle();
      chk("bad start error", 8'(n_err), 8'h01);
      chk("bad start no frame", 8'(n_start), 8'h02);
      chk("no stray byte", 8'(n_byte), 8'h02);
      wrap_up();
   end

endmodule

`default_nettype wire
